/* rbg_pkg.sv */
package rbg_pkg;
    // boot mode codes, op mode pin is the high bit
    typedef enum logic [2:0] {
        RBG_BOOT_EXT16 = 3'h0,
        RBG_BOOT_EPROM = 3'h1,
        RBG_BOOT_HOST = 3'h2,
        RBG_BOOT_RSVD = 3'h3,
        RBG_BOOT_EXT8 = 3'h4,
        RBG_BOOT_UART = 3'h5,
        RBG_BOOT_SPI_SMALL = 3'h6,
        RBG_BOOT_SPI_LARGE = 3'h7
    } rbg_boot_mode_t;

    // start addresses
    localparam logic [23:0] RBG_BOOT_ROM_ADDR = 24'hff0000;
    localparam logic [23:0] RBG_EXT16_STREAM_ADDR = 24'h010000;
    localparam logic [23:0] RBG_EPROM_STREAM_ADDR = 24'h000000;
    localparam logic [23:0] RBG_INTERNAL_START_ADDR = 24'h000000;
    localparam logic [23:0] RBG_EXT8_PAGE1_ADDR = 24'h010000;
    localparam logic [7:0] RBG_SPI_READ_ADDR = 8'h00;
    localparam logic [7:0] RBG_UART_AUTOBAUD_CHAR = 8'haa;

    // external port defaults
    localparam logic [7:0] RBG_CLK_MULT_EXEC = 8'h80;
    localparam logic [7:0] RBG_CLK_MULT_EPROM = 8'h20;
    localparam logic [2:0] RBG_READ_WAITS = 3'h7;

    // spi boot settings
    localparam logic [15:0] RBG_SPI_RATE_DIVISOR = 16'h003c;
    localparam logic RBG_SPI_CPHA = 1'b1;
    localparam logic RBG_SPI_CPOL = 1'b1;
    localparam logic [3:0] RBG_SPI_WORD_BITS = 4'h8;
    localparam logic RBG_SPI_MSB_FIRST = 1'b1;

    // reset configuration field positions
    localparam int RBG_CFG_MODE_LSB = 0;
    localparam int RBG_CFG_MODE_W = 3;

    // grant latency in core clocks, minimum three
    localparam int RBG_GRANT_MIN_DELAY = 3;

    // power-up hold time of reset, kept by the board
    localparam int RBG_POWERUP_HOLD_US = 100;
endpackage : rbg_pkg

/* rbg_boot_decode.sv */
module rbg_boot_decode (
    // selection
    input wire logic [2:0] mode_code,
    // decoded settings
    output logic is_boot,
    output logic [23:0] start_addr,
    output logic [7:0] clk_mult,
    output logic [2:0] read_waits,
    output logic pack_from_8bit,
    output logic spi_chip_select_en,
    output logic uart_autobaud_en,
    output logic host_semaphore_en
);
    // one table for every boot mode so the main block never re-decodes
    always_comb begin
        is_boot = 1'b1;
        start_addr = rbg_pkg::RBG_BOOT_ROM_ADDR;
        clk_mult = rbg_pkg::RBG_CLK_MULT_EXEC;
        read_waits = rbg_pkg::RBG_READ_WAITS;
        pack_from_8bit = 1'b0;
        spi_chip_select_en = 1'b0;
        uart_autobaud_en = 1'b0;
        host_semaphore_en = 1'b0;
        case (rbg_pkg::rbg_boot_mode_t'(mode_code))
            rbg_pkg::RBG_BOOT_EXT16: begin
                start_addr = rbg_pkg::RBG_EXT16_STREAM_ADDR;
            end
            rbg_pkg::RBG_BOOT_EPROM: begin
                start_addr = rbg_pkg::RBG_EPROM_STREAM_ADDR;
                clk_mult = rbg_pkg::RBG_CLK_MULT_EPROM;
            end
            rbg_pkg::RBG_BOOT_HOST: begin
                host_semaphore_en = 1'b1;
            end
            rbg_pkg::RBG_BOOT_EXT8: begin
                is_boot = 1'b0;
                start_addr = rbg_pkg::RBG_EXT8_PAGE1_ADDR;
                pack_from_8bit = 1'b1;
            end
            rbg_pkg::RBG_BOOT_UART: begin
                uart_autobaud_en = 1'b1;
            end
            rbg_pkg::RBG_BOOT_SPI_SMALL, rbg_pkg::RBG_BOOT_SPI_LARGE: begin
                spi_chip_select_en = 1'b1;
            end
            default: begin
                is_boot = 1'b0; // reserved code skips the loader
                start_addr = rbg_pkg::RBG_INTERNAL_START_ADDR;
            end
        endcase
    end
endmodule : rbg_boot_decode

/* rbg_skid_buffer.sv */
module rbg_skid_buffer #(
    parameter int WIDTH = 24
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    // two entries, so a receiver stall never drops a word
    logic [WIDTH-1:0] mem_q [2];
    logic rd_q;
    logic wr_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    initial begin
        if (WIDTH < 1) $error("width must be positive");
    end

    assign push = in_valid && (cnt_q != 2'h2);
    assign pop = out_valid && out_ready;
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_q];

    // storage and pointers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : rbg_skid_buffer

/* rbg_reset_boot_grant.sv */
module rbg_reset_boot_grant #(
    parameter int GRANT_DELAY = rbg_pkg::RBG_GRANT_MIN_DELAY
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // strap pins
    input wire logic op_mode_select_pin,
    input wire logic boot_select_high,
    input wire logic boot_select_low,
    // runtime peripheral choice written by software
    input wire logic op_mode_sw_wr,
    input wire logic op_mode_sw_val,
    // internal bus requests
    input wire logic core_bus_req,
    input wire logic periph_bus_req,
    input wire logic ext_access_req,
    input wire logic dual_read_lock,
    // external arbitration, active low
    input wire logic external_bus_request_b,
    output logic external_bus_grant_b,
    output logic grant_hang_indicator_b,
    output logic bus_drive_oe_b,
    // boot host semaphore cleared by host
    input wire logic host_semaphore_clear,
    // uart autobaud character seen
    input wire logic uart_char_valid,
    input wire logic [7:0] uart_char,
    output logic uart_send_ok,
    // boot status and results
    output logic [2:0] reset_cfg_mode,
    output logic [23:0] pc_start,
    output logic pc_start_valid,
    output logic vectors_internal,
    output logic core_run,
    output logic core_stall,
    output logic int_mask_all,
    output logic stacks_empty,
    output logic sync_serial_port_not_spi,
    output logic spi_boot_chip_select_b,
    output logic [15:0] spi_rate_divisor,
    output logic spi_cpha,
    output logic spi_cpol,
    output logic [7:0] ext_clk_mult,
    output logic [2:0] ext_read_waits,
    output logic ext_pack_8bit,
    // boot word stream into memory
    input wire logic [23:0] boot_word,
    input wire logic boot_word_valid,
    output logic boot_word_ready,
    output logic [23:0] mem_word,
    output logic mem_word_valid,
    input wire logic mem_word_ready
);
    typedef enum logic [2:0] {
        RBG_ST_RESET = 3'h0,
        RBG_ST_HOLD = 3'h1,
        RBG_ST_BOOT = 3'h3,
        RBG_ST_WAIT = 3'h2,
        RBG_ST_RUN = 3'h6
    } rbg_state_t;

    typedef enum logic [1:0] {
        RBG_BUS_OWN = 2'h0,
        RBG_BUS_WAIT = 2'h1,
        RBG_BUS_FLOAT = 2'h3,
        RBG_BUS_GRANTED = 2'h2
    } rbg_bus_t;

    initial begin
        if (GRANT_DELAY < rbg_pkg::RBG_GRANT_MIN_DELAY) $error("grant delay below three");
        if (GRANT_DELAY > 15) $error("grant delay beyond counter");
    end

    rbg_state_t st_q;
    rbg_state_t st_d;
    rbg_bus_t bus_q;
    rbg_bus_t bus_d;
    logic [2:0] mode_q;
    logic strap_taken_q;
    logic [3:0] gcnt_q;
    logic granted;
    logic dec_boot;
    logic [23:0] dec_addr;
    logic [7:0] dec_mult;
    logic [2:0] dec_waits;
    logic dec_pack8;
    logic dec_spi;
    logic dec_uart;
    logic dec_host;
    logic ext_req;
    logic internal_pending;
    logic done_boot;
    logic stream_in_ready;

    rbg_boot_decode u_decode (
        .mode_code(mode_q),
        .is_boot(dec_boot),
        .start_addr(dec_addr),
        .clk_mult(dec_mult),
        .read_waits(dec_waits),
        .pack_from_8bit(dec_pack8),
        .spi_chip_select_en(dec_spi),
        .uart_autobaud_en(dec_uart),
        .host_semaphore_en(dec_host)
    );

    rbg_skid_buffer #(
        .WIDTH(24)
    ) u_stream (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .in_data(boot_word),
        .in_valid(boot_word_valid && (st_q == RBG_ST_BOOT) && !granted),
        .in_ready(stream_in_ready),
        .out_data(mem_word),
        .out_valid(mem_word_valid),
        .out_ready(mem_word_ready)
    );

    assign ext_req = !external_bus_request_b;
    assign internal_pending = core_bus_req || periph_bus_req || dual_read_lock;
    assign granted = (bus_q == RBG_BUS_GRANTED);
    assign boot_word_ready = stream_in_ready && (st_q == RBG_ST_BOOT) && !granted;
    // host boot ends when the semaphore clears; all others, uart included, end when the stream stops
    assign done_boot = dec_host ? host_semaphore_clear : !boot_word_valid;

    // straps sampled on the first edge after release, never in the reset branch
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= 3'h0;
            strap_taken_q <= 1'b0;
        end else if (!strap_taken_q) begin
            mode_q <= {op_mode_select_pin, boot_select_high, boot_select_low};
            strap_taken_q <= 1'b1;
        end
    end

    // boot sequencer
    always_comb begin
        st_d = st_q;
        case (st_q)
            RBG_ST_RESET: st_d = RBG_ST_HOLD;
            RBG_ST_HOLD: begin
                // a pending bus request postpones the boot start
                if (!ext_req && !granted) begin
                    st_d = dec_boot ? RBG_ST_BOOT : RBG_ST_RUN;
                end
            end
            RBG_ST_BOOT: st_d = dec_host ? RBG_ST_WAIT : (done_boot ? RBG_ST_RUN : RBG_ST_BOOT);
            RBG_ST_WAIT: if (host_semaphore_clear) st_d = RBG_ST_RUN;
            RBG_ST_RUN: st_d = RBG_ST_RUN;
            default: st_d = RBG_ST_RESET;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= RBG_ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // start address and vector placement
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_start <= 24'h000000;
            pc_start_valid <= 1'b0;
            vectors_internal <= 1'b0;
        end else begin
            pc_start_valid <= 1'b0;
            if (st_q == RBG_ST_HOLD && st_d == RBG_ST_BOOT) begin
                pc_start <= rbg_pkg::RBG_BOOT_ROM_ADDR;
                pc_start_valid <= 1'b1;
            end else if (st_q == RBG_ST_HOLD && st_d == RBG_ST_RUN) begin
                pc_start <= dec_addr;
                pc_start_valid <= 1'b1;
            end else if (st_q != RBG_ST_RUN && st_d == RBG_ST_RUN) begin
                pc_start <= dec_host ? rbg_pkg::RBG_INTERNAL_START_ADDR : dec_addr;
                pc_start_valid <= 1'b1;
                vectors_internal <= dec_host;
            end
        end
    end

    // core state held at defaults until release
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            int_mask_all <= 1'b1;
            stacks_empty <= 1'b1;
            core_run <= 1'b0;
            core_stall <= 1'b0;
        end else begin
            int_mask_all <= (st_d != RBG_ST_RUN);
            stacks_empty <= (st_d != RBG_ST_RUN) && (st_q != RBG_ST_RUN);
            core_run <= (st_d == RBG_ST_RUN);
            core_stall <= (bus_d == RBG_BUS_GRANTED) && ext_access_req;
        end
    end

    // external port settings for the selected mode
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_clk_mult <= rbg_pkg::RBG_CLK_MULT_EXEC;
            ext_read_waits <= rbg_pkg::RBG_READ_WAITS;
            ext_pack_8bit <= 1'b0;
            reset_cfg_mode <= 3'h0;
        end else if (strap_taken_q) begin
            ext_clk_mult <= dec_mult;
            ext_read_waits <= dec_waits;
            ext_pack_8bit <= dec_pack8;
            reset_cfg_mode <= mode_q;
        end
    end

    // spi boot port setup and chip select
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            spi_boot_chip_select_b <= 1'b1;
            spi_rate_divisor <= 16'h0000;
            spi_cpha <= 1'b0;
            spi_cpol <= 1'b0;
        end else begin
            spi_boot_chip_select_b <= !(dec_spi && st_d == RBG_ST_BOOT);
            if (dec_spi && st_q == RBG_ST_HOLD) begin
                spi_rate_divisor <= rbg_pkg::RBG_SPI_RATE_DIVISOR;
                spi_cpha <= rbg_pkg::RBG_SPI_CPHA;
                spi_cpol <= rbg_pkg::RBG_SPI_CPOL;
            end
        end
    end

    // uart autobaud reply, one pulse per matching character
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            uart_send_ok <= 1'b0;
        end else begin
            uart_send_ok <= dec_uart && st_q == RBG_ST_BOOT && uart_char_valid
                && uart_char == rbg_pkg::RBG_UART_AUTOBAUD_CHAR;
        end
    end

    // serial port versus spi, strap value until software overrides
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_serial_port_not_spi <= 1'b0;
        end else if (op_mode_sw_wr) begin
            sync_serial_port_not_spi <= !op_mode_sw_val;
        end else if (!strap_taken_q) begin
            sync_serial_port_not_spi <= !op_mode_select_pin;
        end
    end

    // bus arbiter; no reset on its flops keeps it live while rst_b is low
    always_comb begin
        bus_d = bus_q;
        case (bus_q)
            RBG_BUS_OWN: if (ext_req) bus_d = RBG_BUS_WAIT;
            RBG_BUS_WAIT: begin
                if (!ext_req) begin
                    bus_d = RBG_BUS_OWN;
                end else if (gcnt_q >= 4'(GRANT_DELAY - 1) && !internal_pending) begin
                    bus_d = RBG_BUS_FLOAT;
                end
            end
            RBG_BUS_FLOAT: bus_d = RBG_BUS_GRANTED;
            RBG_BUS_GRANTED: if (!ext_req) bus_d = RBG_BUS_OWN;
            default: bus_d = RBG_BUS_OWN;
        endcase
    end

    // arbiter runs through reset too, so a request is served before boot
    always_ff @(posedge core_clk) begin
        if (bus_q != RBG_BUS_OWN && bus_q != RBG_BUS_WAIT && bus_q != RBG_BUS_FLOAT
            && bus_q != RBG_BUS_GRANTED) begin
            bus_q <= RBG_BUS_OWN;
        end else begin
            bus_q <= bus_d;
        end
    end

    // grant delay counter
    always_ff @(posedge core_clk) begin
        if (bus_q == RBG_BUS_WAIT && gcnt_q != 4'hf) begin
            gcnt_q <= gcnt_q + 4'h1;
        end else if (bus_q != RBG_BUS_WAIT) begin
            gcnt_q <= 4'h0;
        end
    end

    // pin drivers: float first, grant one cycle later
    always_ff @(posedge core_clk) begin
        bus_drive_oe_b <= (bus_d == RBG_BUS_FLOAT) || (bus_d == RBG_BUS_GRANTED);
        external_bus_grant_b <= !(bus_d == RBG_BUS_GRANTED);
        grant_hang_indicator_b <= !((bus_d == RBG_BUS_GRANTED) && ext_access_req);
    end
endmodule : rbg_reset_boot_grant

/* rbg_reset_boot_grant_chk.sv */
module rbg_reset_boot_grant_chk #(
    parameter int GRANT_DELAY = 3
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // arbitration
    input wire logic external_bus_request_b,
    input wire logic external_bus_grant_b,
    input wire logic grant_hang_indicator_b,
    input wire logic bus_drive_oe_b,
    input wire logic core_bus_req,
    input wire logic periph_bus_req,
    input wire logic dual_read_lock,
    input wire logic ext_access_req,
    input wire logic core_stall,
    // boot
    input wire logic uart_char_valid,
    input wire logic [7:0] uart_char,
    input wire logic uart_send_ok,
    input wire logic [2:0] reset_cfg_mode,
    input wire logic vectors_internal,
    input wire logic spi_boot_chip_select_b,
    input wire logic [15:0] spi_rate_divisor,
    input wire logic spi_cpha,
    input wire logic spi_cpol
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // edges with the request low; unreset, as the arbiter runs in reset
    logic [4:0] req_low_cnt_q = 5'h00;
    always_ff @(posedge core_clk) begin
        if (external_bus_request_b) begin
            req_low_cnt_q <= 5'h00;
        end else if (req_low_cnt_q != 5'h1f) begin
            req_low_cnt_q <= req_low_cnt_q + 5'h01;
        end
    end

    property p_grant_delay;
        $fell(external_bus_grant_b) |-> int'(req_low_cnt_q) >= GRANT_DELAY;
    endproperty
    a_grant_delay: assert property (p_grant_delay)
        else $error("grant too early");
    property p_float_order;
        $fell(external_bus_grant_b) |-> bus_drive_oe_b && $past(bus_drive_oe_b);
    endproperty
    a_float_order: assert property (p_float_order)
        else $error("grant before float");
    property p_float_hold;
        !external_bus_grant_b |-> bus_drive_oe_b;
    endproperty
    a_float_hold: assert property (p_float_hold)
        else $error("bus driven while granted");
    // two cycles of pending so a float already decided is not blamed
    property p_internal_first;
        (!bus_drive_oe_b && (core_bus_req || periph_bus_req))[*2] |=> !bus_drive_oe_b;
    endproperty
    a_internal_first: assert property (p_internal_first)
        else $error("grant over internal request");
    property p_read_lock;
        (!bus_drive_oe_b && dual_read_lock)[*2] |=> !bus_drive_oe_b;
    endproperty
    a_read_lock: assert property (p_read_lock)
        else $error("grant inside read pair");
    property p_release;
        external_bus_request_b && !external_bus_grant_b |-> ##[1:2] external_bus_grant_b;
    endproperty
    a_release: assert property (p_release)
        else $error("grant held after release");
    property p_hold_off;
        (!external_bus_grant_b && ext_access_req)[*2] |-> core_stall && !grant_hang_indicator_b;
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("access not held off");
    property p_no_access;
        (!ext_access_req)[*2] |-> grant_hang_indicator_b && !core_stall;
    endproperty
    a_no_access: assert property (p_no_access)
        else $error("hang without access");
    property p_autobaud;
        uart_send_ok |-> $past(uart_char_valid) && $past(uart_char) == 8'haa
            && reset_cfg_mode == 3'h5;
    endproperty
    a_autobaud: assert property (p_autobaud)
        else $error("ok without autobaud char");
    property p_host_vectors;
        vectors_internal |-> reset_cfg_mode == 3'h2;
    endproperty
    a_host_vectors: assert property (p_host_vectors)
        else $error("remap outside host boot");
    property p_spi_setup;
        !spi_boot_chip_select_b |-> reset_cfg_mode[2:1] == 2'h3
            && spi_rate_divisor == 16'h003c && spi_cpha && spi_cpol;
    endproperty
    a_spi_setup: assert property (p_spi_setup)
        else $error("spi select, bad setup");
endmodule : rbg_reset_boot_grant_chk

bind rbg_reset_boot_grant rbg_reset_boot_grant_chk #(.GRANT_DELAY(GRANT_DELAY)) u_chk (.*);

/* rbg_boot_source.sv */
module rbg_boot_source (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // load order from the bench
    input wire logic load,
    input wire logic [3:0] load_count,
    // word stream towards the device
    output logic [23:0] boot_word,
    output logic boot_word_valid,
    input wire logic boot_word_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] left_q;
    logic [3:0] idx_q;
    // a word stays offered until taken; no pacing of our own once started
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            left_q <= 4'h0;
            idx_q <= 4'h0;
        end else if (load) begin
            left_q <= load_count;
            idx_q <= 4'h0;
        end else if (boot_word_valid && boot_word_ready) begin
            left_q <= left_q - 4'h1;
            idx_q <= idx_q + 4'h1;
        end
    end
    // idle data is inverted so a stale word can never pass for a fresh one
    assign boot_word_valid = (left_q != 4'h0);
    assign boot_word = boot_word_valid ? {20'h5a000, idx_q} : ~{20'h5a000, idx_q};
endmodule : rbg_boot_source

/* test_reset_boot_and_bus_grant.sv */
module test_reset_boot_and_bus_grant;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GD = 3;
    localparam logic [23:0] ROW_PC [8] = '{24'hff0000, 24'hff0000, 24'hff0000, 24'h000000,
        24'h010000, 24'hff0000, 24'hff0000, 24'hff0000};
    localparam logic [7:0] ROW_MULT [8] = '{8'h80, 8'h20, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] strap = 3'h0;
    logic sw_wr = 1'b0, sw_val = 1'b0, core_req = 1'b0, per_req = 1'b0, ext_acc = 1'b0;
    logic lock = 1'b0, br_b = 1'b1, sem_clr = 1'b0, u_vld = 1'b0, load = 1'b0, mem_rdy = 1'b1;
    logic [7:0] u_chr = 8'h00;
    logic bg_b, bgh_b, oe_b, ok, pc_vld, vec_int, run, stall, mask, stk, sync_serial_port, cs_b;
    logic cpha, cpol, pack8, bw_vld, bw_rdy, mw_vld, got, ok1, ok2;
    logic [2:0] cfg, waits, md;
    logic [23:0] pc, bw, mw;
    logic [15:0] div;
    logic [7:0] mult;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    int n;

    // free-running clock, 4 ns period
    initial begin
        forever #2 core_clk = ~core_clk;
    end

    rbg_reset_boot_grant #(.GRANT_DELAY(GD)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .op_mode_select_pin(strap[2]), .boot_select_high(strap[1]), .boot_select_low(strap[0]),
        .op_mode_sw_wr(sw_wr), .op_mode_sw_val(sw_val), .core_bus_req(core_req),
        .periph_bus_req(per_req), .ext_access_req(ext_acc), .dual_read_lock(lock),
        .external_bus_request_b(br_b), .external_bus_grant_b(bg_b),
        .grant_hang_indicator_b(bgh_b), .bus_drive_oe_b(oe_b), .host_semaphore_clear(sem_clr),
        .uart_char_valid(u_vld), .uart_char(u_chr), .uart_send_ok(ok), .reset_cfg_mode(cfg),
        .pc_start(pc), .pc_start_valid(pc_vld), .vectors_internal(vec_int), .core_run(run),
        .core_stall(stall), .int_mask_all(mask), .stacks_empty(stk), .sync_serial_port_not_spi(sync_serial_port),
        .spi_boot_chip_select_b(cs_b), .spi_rate_divisor(div), .spi_cpha(cpha), .spi_cpol(cpol),
        .ext_clk_mult(mult), .ext_read_waits(waits), .ext_pack_8bit(pack8), .boot_word(bw),
        .boot_word_valid(bw_vld), .boot_word_ready(bw_rdy), .mem_word(mw),
        .mem_word_valid(mw_vld), .mem_word_ready(mem_rdy));
    rbg_boot_source u_src (.core_clk(core_clk), .rst_b(rst_b), .load(load), .load_count(4'h8),
        .boot_word(bw), .boot_word_valid(bw_vld), .boot_word_ready(bw_rdy));

    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    // reset with straps held, then order the source to stream eight words
    task automatic boot(input logic [2:0] mode);
        @(negedge core_clk);
        rst_b = 1'b0;
        strap = mode;
        repeat (4) @(negedge core_clk);
        rst_b = 1'b1;
        load = 1'b1;
        @(negedge core_clk);
        load = 1'b0;
    endtask : boot

    task automatic wait_pc(output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 40 && !seen; i++) begin
            if (pc_vld === 1'b1) seen = 1'b1;
            else @(negedge core_clk);
        end
    endtask : wait_pc

    // one character to the autobaud logic; counts ok pulses over the next two cycles
    task automatic uart_send(input logic [7:0] c, input logic [23:0] exp);
        u_chr = c;
        u_vld = 1'b1;
        @(negedge core_clk);
        u_vld = 1'b0;
        ok1 = ok;
        @(negedge core_clk);
        ok2 = ok;
        chk("ok pulses", 24'(ok1) + 24'(ok2), exp);
    endtask : uart_send

    // hang guard: the whole run needs well under two thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        // every boot mode from its strap code
        for (int m = 0; m < 8; m++) begin
            md = 3'(m);
            boot(md);
            wait_pc(got);
            chk("boot start", 24'(got), 24'h1);
            chk("start addr", pc, ROW_PC[m]);
            chk("cfg mode", cfg, md);
            chk("serial choice", sync_serial_port, !md[2]);
            if (ROW_MULT[m] != 8'h00) chk("clk mult", mult, ROW_MULT[m]);
            chk("read waits", waits, 3'h7);
            chk("pack 8bit", pack8, md == 3'h4);
            @(negedge core_clk);
            chk("spi select", cs_b, md < 3'h6);
            if (md >= 3'h6) chk("spi divisor", div, 24'h3c);
            if (md < 3'h2) wait_pc(got);
            if (md < 3'h2) chk("stream start", pc, md == 3'h0 ? 24'h010000 : 24'h0);
        end
        // request during reset: defaults, grant in reset, boot held off
        @(negedge core_clk);
        rst_b = 1'b0;
        br_b = 1'b0;
        repeat (GD + 6) @(negedge core_clk);
        chk("reset mask", {mask, stk, run, cs_b, pc_vld}, 24'h1a);
        chk("reset port", {mult, 1'b0, waits}, 24'h807);
        chk("grant in reset", bg_b, 1'b0);
        rst_b = 1'b1;
        wait_pc(got);
        chk("boot held", 24'(got), 24'h0);
        br_b = 1'b1;
        wait_pc(got);
        chk("boot after release", pc, 24'hff0000);
        // internal requests and a read pair keep the bus
        core_req = 1'b1;
        br_b = 1'b0;
        repeat (12) @(negedge core_clk);
        chk("core first", bg_b, 1'b1);
        core_req = 1'b0;
        lock = 1'b1;
        repeat (12) @(negedge core_clk);
        chk("read pair", bg_b, 1'b1);
        per_req = 1'b1;
        lock = 1'b0;
        repeat (12) @(negedge core_clk);
        chk("periph first", bg_b, 1'b1);
        br_b = 1'b1;
        per_req = 1'b0;
        repeat (3) @(negedge core_clk);
        // fresh request: latency, float, hold-off, release
        br_b = 1'b0;
        n = 0;
        while (bg_b !== 1'b0 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        chk("grant latency", 24'(n >= GD && n < 12), 24'h1);
        chk("floated", oe_b, 1'b1);
        ext_acc = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("stall hang", {stall, bgh_b}, 24'h2);
        br_b = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("resume", {bg_b, oe_b, stall, bgh_b}, 24'h9);
        ext_acc = 1'b0;
        // software overrides the peripheral choice both ways
        sw_val = 1'b1;
        sw_wr = 1'b1;
        @(negedge core_clk);
        sw_wr = 1'b0;
        @(negedge core_clk);
        chk("sw spi", sync_serial_port, 1'b0);
        sw_val = 1'b0;
        sw_wr = 1'b1;
        @(negedge core_clk);
        sw_wr = 1'b0;
        @(negedge core_clk);
        chk("sw serial", sync_serial_port, 1'b1);
        // host boot waits for the semaphore
        boot(3'h2);
        repeat (20) @(negedge core_clk);
        chk("host held", {run, vec_int}, 24'h0);
        sem_clr = 1'b1;
        @(negedge core_clk);
        sem_clr = 1'b0;
        wait_pc(got);
        chk("host jump", pc, 24'h0);
        repeat (2) @(negedge core_clk);
        chk("host run", {run, vec_int}, 24'h3);
        // uart boot with the receiver stalled: buffer fills, then drains in order
        mem_rdy = 1'b0;
        boot(3'h5);
        repeat (6) @(negedge core_clk);
        chk("buffer full", bw_rdy, 1'b0);
        uart_send(8'h55, 24'h0);
        uart_send(8'haa, 24'h1);
        for (int i = 0; i < 8; i++) begin
            n = 0;
            while (mw_vld !== 1'b1 && n < 10) begin
                @(negedge core_clk);
                n++;
            end
            chk("drain word", mw, {20'h5a000, 4'(i)});
            mem_rdy = 1'b1;
            @(negedge core_clk);
            mem_rdy = 1'b0;
            @(negedge core_clk);
        end
        chk("buffer empty", mw_vld, 1'b0);
        print_verdict();
    end
endmodule : test_reset_boot_and_bus_grant
